// ===== include/vca_cfg_pkg.sv
// constants and types for the vca configuration register bank
`default_nettype none
package vca_cfg_pkg;
  // serial frame: 8 address bits then 16 data bits, msb first
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_BITS = 8;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] ADDR_LAST = 5'h07;
  // register addresses
  localparam logic [7:0] FILTER_GAIN_CLAMP_ADDR = 8'h33;
  localparam logic [7:0] TERMINATION_INPUT_GAIN_ADDR = 8'h34;
  localparam logic [7:0] CHANNEL_POWER_ADDR = 8'h35;
  // writable bits per register; reserved bits store and read as zero
  localparam logic [15:0] FILTER_GAIN_CLAMP_MASK = 16'h20fe;
  localparam logic [15:0] TERMINATION_INPUT_GAIN_MASK = 16'hf7ff;
  localparam logic [15:0] CHANNEL_POWER_MASK = 16'h0cff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // field positions in filter_gain_clamp_config
  localparam int unsigned CORNER_LSB = 1;
  localparam int unsigned GA_LOOP_OFF_BIT = 4;
  localparam int unsigned CLAMP_LEVEL_LSB = 5;
  localparam int unsigned CLAMP_OFF_BIT = 7;
  localparam int unsigned GA_GAIN_BIT = 13;
  // field positions in termination_input_gain_config
  localparam int unsigned TERM_CODE_LSB = 0;
  localparam int unsigned TERM_INDIV_BIT = 5;
  localparam int unsigned TERM_PRESET_LSB = 6;
  localparam int unsigned TERM_ON_BIT = 8;
  localparam int unsigned IN_CLAMP_LSB = 9;
  localparam int unsigned PA_LOOP_OFF_BIT = 12;
  localparam int unsigned PA_GAIN_LSB = 13;
  localparam int unsigned PA_PER_CH_BIT = 15;
  // field positions in channel_power_control
  localparam int unsigned PDN_LSB = 0;
  localparam int unsigned LOW_POWER_BIT = 10;
  localparam int unsigned MEDIUM_POWER_SELECT_BIT = 11;
  // field codes
  localparam logic [2:0] CORNER_15 = 3'h0;
  localparam logic [2:0] CORNER_20 = 3'h2;
  localparam logic [2:0] CORNER_30 = 3'h3;
  localparam logic [2:0] CORNER_10 = 3'h4;
  localparam logic [1:0] CLAMP_M2 = 2'h0;
  localparam logic [1:0] CLAMP_M4 = 2'h1;
  localparam logic [1:0] CLAMP_0 = 2'h2;
  localparam logic [1:0] PA_GAIN_12 = 2'h2;
  localparam logic [1:0] PRESET_50 = 2'h0;
  // resistor code derived from each preset; values are plain defaults
  localparam logic [4:0] TERM_CODE_50 = 5'h1f;
  localparam logic [4:0] TERM_CODE_100 = 5'h0f;
  localparam logic [4:0] TERM_CODE_200 = 5'h07;
  localparam logic [4:0] TERM_CODE_400 = 5'h03;
  localparam int unsigned NUM_CH = 8;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;

  typedef struct packed {
    logic [2:0] sen_sync;
    logic [2:0] sclk_sync;
    logic [2:0] sdata_sync;
    logic sen_n_f;
    logic sclk_f;
    ser_state_t state;
    logic [4:0] bit_cnt;
    logic [23:0] shift;
    logic [15:0] read_word;
    logic sdout;
    logic [15:0] filter_gain_clamp_config;
    logic [15:0] termination_input_gain_config;
    logic [15:0] channel_power_control;
  } bank_state_t;
endpackage
`default_nettype wire

// ===== logic/vca_config_register_bank.sv
// serial-programmed configuration bank and decode for the vca chain
//
// Summary of operation
// - corner code 000/010/011/100 selects 15/20/30/10 MHz filter corner.
// - gain amplifier offset integrator on when bit clear, off when set.
// - with clamp enabled, level 00/10/01 selects -2/0/-4 dBFS.
// - clamp-disable bit zero enables clamp; one disables, level ignored.
// - individual resistor code acts only while its enable bit is one.
// - preset 00..11 picks 50/100/200/400 ohm; resistor code derived.
// - at 12 dB preamp gain, preset 00 means high impedance input.
// - input clamp 00 auto, 01 1.5 Vpp, 10 1.15 Vpp, 11 0.6 Vpp.
// - preamp offset integrator on when bit zero, off when one.
// - common preamp gain 00 18 dB, 01 24 dB, 10 12 dB, 11 reserved.
// - per-channel gain bit switches gain source to per-channel fields.
// - power-down bit n shuts channel n+1; clear means normal.
// - power-down hits whichever blocks are active in current mode.
// - low-power bit one selects low power, zero low noise.
// - medium-power bit one selects medium power; low-power kept clear.
// - mode bit zero imaging gain mode, one continuous-wave mode.
// - per-channel gain fields share encoding, act only when enabled.
`default_nettype none
module vca_config_register_bank
  import vca_cfg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial configuration port
  input wire logic sen_n_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic readout_en_in,
  output logic sdout_out,
  // settings held elsewhere in the map
  input wire logic chain_mode_select_in,
  input wire logic [15:0] preamp_channel_gain_in,
  // filter and gain amplifier
  output logic [3:0] filter_corner_select_out,
  output logic gain_amp_offset_loop_on_out,
  output logic gain_amp_clamp_on_out,
  output logic [2:0] gain_amp_clamp_level_out,
  output logic gain_amp_30db_out,
  // termination and preamp
  output logic termination_on_out,
  output logic [3:0] termination_preset_out,
  output logic termination_hi_z_out,
  output logic [4:0] termination_code_out,
  output logic [3:0] input_clamp_select_out,
  output logic preamp_offset_loop_on_out,
  output logic [15:0] preamp_gain_select_out,
  // power
  output logic [7:0] imaging_gain_mode_pdn_out,
  output logic [7:0] continuous_wave_mode_pdn_out,
  output logic low_power_out,
  output logic medium_power_select_out
);
  bank_state_t s_r;
  bank_state_t s_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_end;
  logic [23:0] word;
  logic [1:0] common_gain;
  logic [15:0] r33;
  logic [15:0] r34;
  logic [15:0] r35;

  assign r33 = s_r.filter_gain_clamp_config;
  assign r34 = s_r.termination_input_gain_config;
  assign r35 = s_r.channel_power_control;

  always_comb begin
    s_nxt = s_r;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    frame_end = 1'b0;
    word = {s_r.shift[22:0], s_r.sdata_sync[2]};
    s_nxt.sen_sync = {s_r.sen_sync[1:0], sen_n_in};
    s_nxt.sclk_sync = {s_r.sclk_sync[1:0], sclk_in};
    s_nxt.sdata_sync = {s_r.sdata_sync[1:0], sdata_in};
    // filtered levels move only when stages two and three agree
    if (s_r.sen_sync[1] == s_r.sen_sync[2]) begin
      s_nxt.sen_n_f = s_r.sen_sync[2];
    end
    if (s_r.sclk_sync[1] == s_r.sclk_sync[2]) begin
      s_nxt.sclk_f = s_r.sclk_sync[2];
      sclk_rise = s_r.sclk_sync[2] & ~s_r.sclk_f;
      sclk_fall = ~s_r.sclk_sync[2] & s_r.sclk_f;
    end
    case (s_r.state)
      SER_IDLE: begin
        s_nxt.bit_cnt = 5'h00;
        s_nxt.sdout = 1'b0;
        if (!s_r.sen_n_f) begin
          s_nxt.state = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (s_r.sen_n_f) begin
          s_nxt.state = SER_IDLE;
        end else if (sclk_rise) begin
          s_nxt.shift = word;
          s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
          if (s_r.bit_cnt == ADDR_LAST) begin
            case (word[ADDR_BITS-1:0])
              FILTER_GAIN_CLAMP_ADDR: s_nxt.read_word = r33;
              TERMINATION_INPUT_GAIN_ADDR: s_nxt.read_word = r34;
              CHANNEL_POWER_ADDR: s_nxt.read_word = r35;
              default: s_nxt.read_word = REG_RESET;
            endcase
          end
          if (s_r.bit_cnt == FRAME_LAST) begin
            frame_end = 1'b1;
            s_nxt.state = SER_IDLE;
          end
        end else if (sclk_fall && s_r.bit_cnt > ADDR_LAST) begin
          // readback data shifts out msb first on falling edges
          s_nxt.sdout = readout_en_in & s_r.read_word[15];
          s_nxt.read_word = {s_r.read_word[14:0], 1'b0};
        end
      end
      default: begin
        s_nxt.state = SER_IDLE;
      end
    endcase
    if (frame_end && !readout_en_in) begin
      case (word[FRAME_BITS-1:FRAME_BITS-ADDR_BITS])
        FILTER_GAIN_CLAMP_ADDR:
          s_nxt.filter_gain_clamp_config =
            word[15:0] & FILTER_GAIN_CLAMP_MASK;
        TERMINATION_INPUT_GAIN_ADDR:
          s_nxt.termination_input_gain_config =
            word[15:0] & TERMINATION_INPUT_GAIN_MASK;
        CHANNEL_POWER_ADDR:
          s_nxt.channel_power_control = word[15:0] & CHANNEL_POWER_MASK;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.state <= SER_IDLE;
      s_r.sen_sync <= 3'h7;
      s_r.sen_n_f <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sdout_out = s_r.sdout;

  always_comb begin
    case (r33[CORNER_LSB +: 3])
      CORNER_15: filter_corner_select_out = 4'h1;
      CORNER_20: filter_corner_select_out = 4'h2;
      CORNER_30: filter_corner_select_out = 4'h4;
      CORNER_10: filter_corner_select_out = 4'h8;
      default: filter_corner_select_out = 4'h0;
    endcase
  end

  assign gain_amp_offset_loop_on_out = ~r33[GA_LOOP_OFF_BIT];
  assign gain_amp_clamp_on_out = ~r33[CLAMP_OFF_BIT];

  always_comb begin
    gain_amp_clamp_level_out = 3'h0;
    if (!r33[CLAMP_OFF_BIT]) begin
      case (r33[CLAMP_LEVEL_LSB +: 2])
        CLAMP_M4: gain_amp_clamp_level_out = 3'h1;
        CLAMP_M2: gain_amp_clamp_level_out = 3'h2;
        CLAMP_0: gain_amp_clamp_level_out = 3'h4;
        default: gain_amp_clamp_level_out = 3'h0;
      endcase
    end
  end

  // gain amp gain and termination enable
  assign gain_amp_30db_out = r33[GA_GAIN_BIT];
  assign termination_on_out = r34[TERM_ON_BIT];

  assign common_gain = r34[PA_GAIN_LSB +: 2];
  // preset 00 at 12 dB means high impedance
  assign termination_hi_z_out = (r34[TERM_PRESET_LSB +: 2] == PRESET_50) &&
                                (common_gain == PA_GAIN_12);

  // preset one-hot {400,200,100,50} and derived code
  always_comb begin
    termination_preset_out = 4'h0;
    termination_preset_out[r34[TERM_PRESET_LSB +: 2]] = 1'b1;
    if (termination_hi_z_out) begin
      termination_preset_out = 4'h0;
    end
    case (r34[TERM_PRESET_LSB +: 2])
      2'h0: termination_code_out = TERM_CODE_50;
      2'h1: termination_code_out = TERM_CODE_100;
      2'h2: termination_code_out = TERM_CODE_200;
      default: termination_code_out = TERM_CODE_400;
    endcase
    if (r34[TERM_INDIV_BIT]) begin
      termination_code_out = r34[TERM_CODE_LSB +: 5];
    end
  end

  always_comb begin
    input_clamp_select_out = 4'h0;
    input_clamp_select_out[r34[IN_CLAMP_LSB +: 2]] = 1'b1;
  end

  assign preamp_offset_loop_on_out = ~r34[PA_LOOP_OFF_BIT];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign preamp_gain_select_out[2*ch +: 2] = r34[PA_PER_CH_BIT] ?
          preamp_channel_gain_in[2*ch +: 2] : common_gain;
    end
  endgenerate

  assign imaging_gain_mode_pdn_out =
      r35[PDN_LSB +: NUM_CH] & {NUM_CH{~chain_mode_select_in}};
  assign continuous_wave_mode_pdn_out =
      r35[PDN_LSB +: NUM_CH] & {NUM_CH{chain_mode_select_in}};

  // power mode; medium wins if both set
  assign medium_power_select_out = r35[MEDIUM_POWER_SELECT_BIT];
  assign low_power_out = r35[LOW_POWER_BIT] & ~r35[MEDIUM_POWER_SELECT_BIT];
endmodule
`default_nettype wire

// ===== tb/vca_config_register_bank_chk.sv
// port assertions for the vca configuration register bank
`default_nettype none
module vca_bank_chk (
  // clock, reset and mode
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic chain_mode_select_in,
  // decoded settings
  input wire logic [3:0] filter_corner_select_out,
  input wire logic gain_amp_clamp_on_out,
  input wire logic [2:0] gain_amp_clamp_level_out,
  input wire logic [3:0] termination_preset_out,
  input wire logic termination_hi_z_out,
  input wire logic [4:0] termination_code_out,
  input wire logic [3:0] input_clamp_select_out,
  input wire logic [7:0] imaging_gain_mode_pdn_out,
  input wire logic [7:0] continuous_wave_mode_pdn_out,
  input wire logic low_power_out,
  input wire logic medium_power_select_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  property p_rst_vals;
    $fell(rst_in) |-> filter_corner_select_out == 4'h1 &&
      termination_code_out == 5'h1f && imaging_gain_mode_pdn_out == 8'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset");
  property p_filter;
    $onehot0(filter_corner_select_out);
  endproperty
  a_filter: assert property (p_filter) else $error("corner code");
  property p_clamp_off;
    !gain_amp_clamp_on_out |-> gain_amp_clamp_level_out == 3'h0;
  endproperty
  a_clamp_off: assert property (p_clamp_off) else $error("clamp");
  property p_clamp_lvl;
    $onehot0(gain_amp_clamp_level_out);
  endproperty
  a_clamp_lvl: assert property (p_clamp_lvl) else $error("level");
  property p_hiz;
    termination_hi_z_out |-> termination_preset_out == 4'h0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hi-z preset");
  property p_preset;
    !termination_hi_z_out |-> $onehot(termination_preset_out);
  endproperty
  a_preset: assert property (p_preset) else $error("preset");
  property p_in_clamp;
    $onehot(input_clamp_select_out);
  endproperty
  a_in_clamp: assert property (p_in_clamp) else $error("in clamp");
  property p_mode;
    chain_mode_select_in ? imaging_gain_mode_pdn_out == 8'h0
      : continuous_wave_mode_pdn_out == 8'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_power;
    medium_power_select_out |-> !low_power_out;
  endproperty
  a_power: assert property (p_power) else $error("power");
  c_hiz: cover property (termination_hi_z_out);
  c_cw: cover property (continuous_wave_mode_pdn_out != 8'h0);
  c_med: cover property (medium_power_select_out);
endmodule
bind vca_config_register_bank vca_bank_chk chk_i (.*);
`default_nettype wire

// ===== tb/vca_config_register_bank_bench.sv
// self-checking bench for the vca configuration register bank
`default_nettype none
module vca_config_register_bank_bench import vca_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sen_n_in = 1'b1, sclk_in = 1'b0, sdata_in = 1'b0;
  logic readout_en_in = 1'b0, chain_mode_select_in = 1'b0;
  logic [15:0] preamp_channel_gain_in = 16'h0;
  logic sdout_out, gain_amp_offset_loop_on_out, gain_amp_clamp_on_out;
  logic gain_amp_30db_out, termination_on_out, termination_hi_z_out;
  logic preamp_offset_loop_on_out, low_power_out, medium_power_select_out;
  logic [3:0] filter_corner_select_out, termination_preset_out;
  logic [3:0] input_clamp_select_out;
  logic [2:0] gain_amp_clamp_level_out;
  logic [4:0] termination_code_out;
  logic [15:0] preamp_gain_select_out, d, q, last;
  logic [23:0] cut = {CHANNEL_POWER_ADDR, 16'h00ff};
  logic [7:0] imaging_gain_mode_pdn_out, continuous_wave_mode_pdn_out;
  int miscompares = 0, comparisons = 0, cycles = 0;
  integer seed = 32'h2ff9;
  wire [31:0] o33 = {22'h0, filter_corner_select_out,
    gain_amp_offset_loop_on_out, gain_amp_clamp_on_out,
    gain_amp_clamp_level_out, gain_amp_30db_out};
  wire [31:0] o34 = {termination_on_out, termination_preset_out,
    termination_hi_z_out, termination_code_out, input_clamp_select_out,
    preamp_offset_loop_on_out, preamp_gain_select_out};
  wire [31:0] o35 = {14'h0, imaging_gain_mode_pdn_out,
    continuous_wave_mode_pdn_out, low_power_out, medium_power_select_out};
  vca_config_register_bank uut (.*);
  always #5 ref_clk_in = ~ref_clk_in;
  task report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] f33(input logic [15:0] v);
    logic [3:0] c;
    logic [2:0] l;
    case (v[3:1])
      3'h0: c = 4'h1;
      3'h2: c = 4'h2;
      3'h3: c = 4'h4;
      3'h4: c = 4'h8;
      default: c = 4'h0;
    endcase
    case (v[6:5])
      2'h0: l = 3'h2;
      2'h1: l = 3'h1;
      2'h2: l = 3'h4;
      default: l = 3'h0;
    endcase
    if (v[7]) l = 3'h0;
    return {22'h0, c, ~v[4], ~v[7], l, v[13]};
  endfunction
  function automatic logic [31:0] f34(input logic [15:0] v,
      input logic [15:0] g);
    logic hz;
    logic [4:0] tc;
    hz = v[7:6] == 2'h0 && v[14:13] == 2'h2;
    tc = v[5] ? v[4:0] : 5'h1f >> v[7:6];
    return {v[8], (hz ? 4'h0 : 4'h1 << v[7:6]), hz, tc, 4'h1 << v[10:9],
      ~v[12], (v[15] ? g : {8{v[14:13]}})};
  endfunction
  function automatic logic [31:0] f35(input logic [15:0] v, input logic m);
    return {14'h0, (m ? 8'h0 : v[7:0]), (m ? v[7:0] : 8'h0),
      v[10] & ~v[11], v[11]};
  endfunction
  task frame(input logic [7:0] a, input logic [15:0] v, input logic rd);
    logic [23:0] w;
    w = {a, v};
    readout_en_in = rd;
    sen_n_in = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdata_in = w[i];
      repeat (4) @(negedge ref_clk_in);
      sclk_in = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      if (i < 16) q[i] = sdout_out;
      sclk_in = 1'b0;
    end
    repeat (6) @(negedge ref_clk_in);
    sen_n_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    readout_en_in = 1'b0;
  endtask
  task read_chk(input logic [7:0] a, input logic [15:0] exp);
    frame(a, 16'h0, 1'b1);
    chk({16'h0, q}, {16'h0, exp});
  endtask
  initial begin
    repeat (3) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    chk(o33, f33(16'h0));
    chk(o34, f34(16'h0, 16'h0));
    read_chk(FILTER_GAIN_CLAMP_ADDR, 16'h0);
    for (int k = 0; k < 8; k++) begin
      d = 16'($random(seed)) & FILTER_GAIN_CLAMP_MASK;
      d[7:1] = {k[0], k[2:1], d[4], k[2:0]};
      frame(FILTER_GAIN_CLAMP_ADDR, d, 1'b0);
      chk(o33, f33(d));
      read_chk(FILTER_GAIN_CLAMP_ADDR, d);
    end
    for (int k = 0; k < 16; k++) begin
      d = 16'($random(seed)) & TERMINATION_INPUT_GAIN_MASK;
      preamp_channel_gain_in = 16'($random(seed)) & 16'h9999;
      if (d[14:13] == 2'h3) d[13] = 1'b0;
      // force preset 00 at 12 dB
      if (k < 2) begin
        d[14:13] = PA_GAIN_12;
        d[7:6] = PRESET_50;
      end
      d[5] = k[0];
      frame(TERMINATION_INPUT_GAIN_ADDR, d, 1'b0);
      chk(o34, f34(d, preamp_channel_gain_in));
      chk(o34, f34(d, preamp_channel_gain_in));
      chk(o34, f34(d, preamp_channel_gain_in));
      read_chk(TERMINATION_INPUT_GAIN_ADDR, d);
    end
    for (int k = 0; k < 16; k++) begin
      d = 16'($random(seed)) & CHANNEL_POWER_MASK;
      if (d[11]) d[10] = 1'b0;
      frame(CHANNEL_POWER_ADDR, d, 1'b0);
      chk(o35, f35(d, chain_mode_select_in));
      chain_mode_select_in = ~chain_mode_select_in;
      @(negedge ref_clk_in);
      chk(o35, f35(d, chain_mode_select_in));
      read_chk(CHANNEL_POWER_ADDR, d);
    end
    last = d;
    frame(8'h36, 16'h00ff, 1'b0);
    read_chk(CHANNEL_POWER_ADDR, last);
    frame(CHANNEL_POWER_ADDR, 16'h00a5, 1'b1);
    read_chk(CHANNEL_POWER_ADDR, last);
    sen_n_in = 1'b0;
    for (int i = 23; i >= 12; i--) begin
      sdata_in = cut[i];
      repeat (4) @(negedge ref_clk_in);
      sclk_in = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      sclk_in = 1'b0;
    end
    repeat (6) @(negedge ref_clk_in);
    sen_n_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    read_chk(CHANNEL_POWER_ADDR, last);
    rst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    chk(o33, f33(16'h0));
    chk(o35, f35(16'h0, chain_mode_select_in));
    read_chk(CHANNEL_POWER_ADDR, 16'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
